// ===== hw/rcw_reset_ctrl.sv
/*
 * Reset source capture, reset sequencing and watchdog control.
 * Assumes a 100 MHz clock, an 8-bit register port on the same clock,
 * asynchronous reset-source pins and a system clock activity tick.
 */
`include "rcw_map.svh"

module rcw_reset_ctrl #(
    parameter int MCD_CYCLES = `RCW_MCD_MIN_CYC,
    parameter int STRETCH_CYCLES = `RCW_STRETCH_CYC,
    parameter int PIN_DRIVE_CYCLES = `RCW_PIN_DRIVE_CYC
) (
    // clock and power-on reset
    input wire logic clock,
    input wire logic sys_rst,
    // special-function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr_en,
    input wire logic sfr_rd_en,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // asynchronous reset-source pins
    input wire rcw_pkg::rcw_pins_s async_pins,
    // system clock activity
    input wire logic clk_tick,
    // reset outputs
    output logic core_rst,
    output logic rst_pin_o,
    output logic rst_pin_oe
);

    localparam int STW = $clog2(STRETCH_CYCLES + 1);
    localparam int DRW = $clog2(PIN_DRIVE_CYCLES + 1);

    rcw_pkg::rcw_pins_s sync1_ff, pins_ff;
    rcw_pkg::rcw_state_e state_ff;
    rcw_pkg::rcw_flags_s flags_ff, nxt_flags;
    logic [STW-1:0] stretch_cnt_ff;
    logic [DRW-1:0] drive_cnt_ff, nxt_drive_cnt;
    logic pin_drv_ff, cnv_en_ff, cmp_en_ff, mcd_en_ff, por_sel_ff;
    logic wd_run_ff, wd_lock_ff;
    logic [2:0] wd_sel_ff, dis_win_ff;
    logic [7:0] rdata_ff;
    logic in_run, wr_wd, wr_cause, rd_wd, rd_cause;
    logic wd_restart, wd_expire, mcd_timeout;
    logic src_pin, src_sup, src_cmp, src_cnv, src_sw, src_force;
    logic enter_rst, hold_cond;

    // register address match, used by every read and write decode
    function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] off);
        return addr == off;
    endfunction

    // two-flop synchronisers for the asynchronous pins
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_ff <= `RCW_PINS_IDLE;
            pins_ff <= `RCW_PINS_IDLE;
        end else begin
            sync1_ff <= async_pins;
            pins_ff <= sync1_ff;
        end
    end

    // register port decode; writes only land while the core runs
    assign in_run = (state_ff == rcw_pkg::RCW_RUN);
    assign wr_wd = sfr_wr_en && in_run && sfr_hit(sfr_addr, `RCW_ADDR_WDOG);
    assign wr_cause = sfr_wr_en && in_run && sfr_hit(sfr_addr, `RCW_ADDR_CAUSE);
    assign rd_wd = sfr_rd_en && sfr_hit(sfr_addr, `RCW_ADDR_WDOG);
    assign rd_cause = sfr_rd_en && sfr_hit(sfr_addr, `RCW_ADDR_CAUSE);

    assign wd_restart = wr_wd && (sfr_wdata == `RCW_WD_ENABLE);

    // reset sources, all start a reset only while running; pin and monitor levels also hold it
    assign src_pin = !pins_ff.pin;
    // monitor acts only when its enable pin is high
    assign src_sup = pins_ff.supply_monitor_enable_pin && por_sel_ff && pins_ff.supply_low;
    // comparator low level resets when enabled
    assign src_cmp = cmp_en_ff && !pins_ff.cmp;
    // convert-start low level resets when enabled
    assign src_cnv = cnv_en_ff && !pins_ff.cnv;
    assign src_sw = wr_cause && sfr_wdata[`RCW_BIT_SW];
    assign src_force = wr_cause && sfr_wdata[`RCW_BIT_PIN];

    // watchdog expiry is a reset source like the others
    assign enter_rst = in_run && (src_pin || src_sup || src_cmp || src_cnv || mcd_timeout
        || wd_expire || src_sw || src_force);

    // pin and supply-monitor levels and the pin drive keep the core held
    assign hold_cond = src_pin || src_sup || (drive_cnt_ff != '0);

    // pick one cause by priority, all others clear
    always_comb begin
        nxt_flags = '0;
        // power-on flag for forced or monitor reset
        if (src_force || src_sup) begin
            nxt_flags.por = 1'b1;
        end else if (src_pin) begin
            nxt_flags.pin = 1'b1;
        end else if (src_cmp) begin
            nxt_flags.cmp = 1'b1;
        end else if (src_cnv) begin
            nxt_flags.cnv = 1'b1;
        end else if (mcd_timeout) begin
            nxt_flags.mcd = 1'b1;
        end else if (wd_expire) begin
            nxt_flags.wdog = 1'b1;
        end else begin
            nxt_flags.sw = 1'b1;
        end
    end

    // cause flags; power-on leaves only the power flag set
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            flags_ff <= `RCW_FLAGS_POR;
        end else if (enter_rst) begin
            flags_ff <= nxt_flags;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= rcw_pkg::RCW_STRETCH;
            stretch_cnt_ff <= '0;
        end else begin
            case (state_ff)
                rcw_pkg::RCW_RUN: begin
                    if (enter_rst) begin
                        state_ff <= rcw_pkg::RCW_HOLD;
                    end
                end
                rcw_pkg::RCW_HOLD: begin
                    if (!hold_cond) begin
                        state_ff <= rcw_pkg::RCW_STRETCH;
                        stretch_cnt_ff <= '0;
                    end
                end
                rcw_pkg::RCW_STRETCH: begin
                    if (hold_cond) begin
                        state_ff <= rcw_pkg::RCW_HOLD;
                    end else if (stretch_cnt_ff == STW'(STRETCH_CYCLES - 1)) begin
                        state_ff <= rcw_pkg::RCW_RUN;
                    end else begin
                        stretch_cnt_ff <= stretch_cnt_ff + 1'b1;
                    end
                end
                default: begin
                    state_ff <= rcw_pkg::RCW_HOLD;
                end
            endcase
        end
    end

    // reset pin drive length on a forced power-on reset
    always_comb begin
        nxt_drive_cnt = drive_cnt_ff;
        if (enter_rst && src_force) begin
            nxt_drive_cnt = DRW'(PIN_DRIVE_CYCLES);
        end else if (drive_cnt_ff != '0) begin
            nxt_drive_cnt = drive_cnt_ff - 1'b1;
        end
    end

    // pin driven for a forced reset or while the monitor holds reset
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            drive_cnt_ff <= '0;
            pin_drv_ff <= 1'b0;
        end else begin
            drive_cnt_ff <= nxt_drive_cnt;
            pin_drv_ff <= (nxt_drive_cnt != '0) || src_sup;
        end
    end

    // reset source enables, back to defaults on every reset
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cnv_en_ff <= `RCW_SRC_EN_RST;
            cmp_en_ff <= `RCW_SRC_EN_RST;
            mcd_en_ff <= `RCW_SRC_EN_RST;
            por_sel_ff <= `RCW_POR_SEL_RST;
        end else if (enter_rst) begin
            cnv_en_ff <= `RCW_SRC_EN_RST;
            cmp_en_ff <= `RCW_SRC_EN_RST;
            mcd_en_ff <= `RCW_SRC_EN_RST;
            por_sel_ff <= `RCW_POR_SEL_RST;
        end else if (wr_cause) begin
            cnv_en_ff <= sfr_wdata[`RCW_BIT_CNV];
            cmp_en_ff <= sfr_wdata[`RCW_BIT_CMP];
            mcd_en_ff <= sfr_wdata[`RCW_BIT_MCD];
            // selection changes only with monitor enabled
            if (pins_ff.supply_monitor_enable_pin) begin
                por_sel_ff <= sfr_wdata[`RCW_BIT_POR];
            end
        end
    end

    // watchdog control, held at defaults through reset
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wd_run_ff <= `RCW_WD_RUN_RST;
            wd_sel_ff <= `RCW_WD_SEL_RST;
            wd_lock_ff <= `RCW_WD_LOCK_RST;
            dis_win_ff <= '0;
        end else if (!in_run) begin
            // lockout cleared only by a reset
            wd_run_ff <= `RCW_WD_RUN_RST;
            wd_sel_ff <= `RCW_WD_SEL_RST;
            wd_lock_ff <= `RCW_WD_LOCK_RST;
            dis_win_ff <= '0;
        end else begin
            if (wd_restart) begin
                wd_run_ff <= 1'b1;
            end
            // second disable byte inside the window
            if (wr_wd && (sfr_wdata == `RCW_WD_DIS_SECOND) && (dis_win_ff != '0)
                && !wd_lock_ff) begin
                wd_run_ff <= 1'b0;
            end
            if (wr_wd && (sfr_wdata == `RCW_WD_LOCK)) begin
                wd_lock_ff <= 1'b1;
            end
            // interval update only with bit 7 clear
            if (wr_wd && !sfr_wdata[`RCW_WD_WRMODE_BIT]) begin
                wd_sel_ff <= sfr_wdata[2:0];
            end
            // window opened by the first disable byte
            if (wr_wd && (sfr_wdata == `RCW_WD_DIS_FIRST)) begin
                dis_win_ff <= `RCW_WD_DIS_WINDOW;
            end else if (dis_win_ff != '0) begin
                dis_win_ff <= dis_win_ff - 1'b1;
            end
        end
    end

    // watchdog counter, held cleared outside run
    rcw_wdog_counter #(
        .CNT_W(`RCW_WD_CNT_W)
    ) u_wdog (
        .clock(clock),
        .sys_rst(sys_rst),
        .run(wd_run_ff && in_run),
        .restart(wd_restart),
        .sel(wd_sel_ff),
        .expire(wd_expire)
    );

    // missing clock detector, enabled from the cause register
    rcw_mcd #(
        .CYCLES(MCD_CYCLES)
    ) u_mcd (
        .clock(clock),
        .sys_rst(sys_rst),
        .enable(mcd_en_ff && in_run),
        .clk_tick(clk_tick),
        .timeout(mcd_timeout)
    );

    // registered read data; unmapped reads keep the last value
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_ff <= `RCW_RDATA_RST;
        end else if (rd_cause) begin
            rdata_ff <= {1'b0, flags_ff};
        end else if (rd_wd) begin
            rdata_ff <= {3'h0, wd_run_ff, 1'b0, wd_sel_ff};
        end
    end

    // outputs; the pin is open drain, only ever pulled low
    assign sfr_rdata = rdata_ff;
    assign core_rst = !in_run;
    assign rst_pin_o = 1'b0;
    assign rst_pin_oe = pin_drv_ff;

    a_wd_enable_cmd: assert property (@(posedge clock) disable iff (sys_rst)
        wd_restart |=> wd_run_ff)
        else $error("a5 did not enable watchdog");

    a_wd_disable_pair: assert property (@(posedge clock) disable iff (sys_rst)
        (wr_wd && sfr_wdata == `RCW_WD_DIS_FIRST && !wd_lock_ff) ##1
        (wr_wd && sfr_wdata == `RCW_WD_DIS_SECOND && in_run) |=> !wd_run_ff)
        else $error("disable pair did not stop watchdog");

    a_wd_late_disable: assert property (@(posedge clock) disable iff (sys_rst)
        (wr_wd && sfr_wdata == `RCW_WD_DIS_SECOND && dis_win_ff == 3'h0 && wd_run_ff)
        |=> wd_run_ff)
        else $error("late disable byte stopped watchdog");

    a_wd_lock_norun: assert property (@(posedge clock) disable iff (sys_rst)
        (wr_wd && sfr_wdata == `RCW_WD_LOCK && !wd_run_ff) |=> !wd_run_ff && wd_lock_ff)
        else $error("lock write changed run state");

    a_wd_lock_held: assert property (@(posedge clock) disable iff (sys_rst)
        (wd_lock_ff && in_run && !enter_rst) |=> wd_lock_ff)
        else $error("lockout dropped without reset");

    a_wd_status_read: assert property (@(posedge clock) disable iff (sys_rst)
        rd_wd && !rd_cause |=> sfr_rdata[`RCW_WD_RUN_BIT] == $past(wd_run_ff)
        && sfr_rdata[2:0] == $past(wd_sel_ff))
        else $error("watchdog status read wrong");

    a_wd_sel_guard: assert property (@(posedge clock) disable iff (sys_rst)
        (in_run && !enter_rst && wr_wd && sfr_wdata[`RCW_WD_WRMODE_BIT]) |=> $stable(wd_sel_ff))
        else $error("interval changed by bit7 write");

    a_wd_reset_dflt: assert property (@(posedge clock) disable iff (sys_rst)
        enter_rst |=> core_rst ##1 (wd_sel_ff == `RCW_WD_SEL_RST && wd_run_ff))
        else $error("watchdog defaults not restored");

    a_cause_onehot: assert property (@(posedge clock) disable iff (sys_rst)
        enter_rst |=> $onehot(flags_ff) && !cnv_en_ff && !cmp_en_ff && !mcd_en_ff)
        else $error("cause flags not one-hot after reset");

    a_wd_expire_rst: assert property (@(posedge clock) disable iff (sys_rst)
        (wd_expire && in_run && !src_pin && !src_sup && !src_force && !src_cmp && !src_cnv
        && !mcd_timeout) |=> flags_ff.wdog && core_rst && !rst_pin_oe)
        else $error("watchdog expiry mishandled");

    a_force_drives_pin: assert property (@(posedge clock) disable iff (sys_rst)
        (src_force && in_run) |=> rst_pin_oe && flags_ff.por)
        else $error("forced reset did not drive pin");

    a_mon_sel_guard: assert property (@(posedge clock) disable iff (sys_rst)
        (wr_cause && !pins_ff.supply_monitor_enable_pin && !enter_rst) |=> $stable(por_sel_ff))
        else $error("monitor select changed while disabled");

    a_stretch_hold: assert property (@(posedge clock) disable iff (sys_rst)
        (state_ff == rcw_pkg::RCW_STRETCH && stretch_cnt_ff < STW'(STRETCH_CYCLES - 1))
        |=> core_rst)
        else $error("reset released before stretch end");

endmodule // rcw_reset_ctrl

// ===== hw/rcw_map.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * reset-cause and watchdog block.
 * Assumes a single 100 MHz clock and an 8-bit special-function register port.
 */
`ifndef RCW_MAP_SVH
`define RCW_MAP_SVH

// register offsets on the special-function register port
`define RCW_ADDR_CAUSE 8'hef
`define RCW_ADDR_WDOG 8'hff

// watchdog control command values
`define RCW_WD_ENABLE 8'ha5
`define RCW_WD_DIS_FIRST 8'hde
`define RCW_WD_DIS_SECOND 8'had
`define RCW_WD_LOCK 8'hff
`define RCW_WD_DIS_WINDOW 3'h4
`define RCW_WD_SEL_RST 3'h7
`define RCW_WD_RUN_RST 1'b1
`define RCW_WD_LOCK_RST 1'b0
`define RCW_WD_WRMODE_BIT 7
`define RCW_WD_RUN_BIT 4
`define RCW_WD_CNT_W 21
`define RCW_WD_BASE_EXP 3

// reset cause register bit positions
`define RCW_BIT_CNV 6
`define RCW_BIT_CMP 5
`define RCW_BIT_SW 4
`define RCW_BIT_WDOG 3
`define RCW_BIT_MCD 2
`define RCW_BIT_POR 1
`define RCW_BIT_PIN 0

// reset values
`define RCW_FLAGS_POR 7'h02
`define RCW_SRC_EN_RST 1'b0
`define RCW_POR_SEL_RST 1'b1
`define RCW_PINS_IDLE 5'h07
`define RCW_RDATA_RST 8'h00

// timing
`define RCW_CLK_MHZ 100
`define RCW_MCD_MIN_US 100
`define RCW_MCD_MAX_US 500
`define RCW_MCD_MIN_CYC (`RCW_MCD_MIN_US * `RCW_CLK_MHZ)
`define RCW_STRETCH_CYC 12
`define RCW_PIN_DRIVE_CYC 16

`endif

// ===== hw/rcw_pkg.sv
/*
 * Types shared by the reset-cause and watchdog block.
 * Assumes nothing beyond a SystemVerilog tool.
 */
package rcw_pkg;

    // reset sequencer states, one-hot
    typedef enum logic [2:0] {
        RCW_RUN = 3'h1,
        RCW_HOLD = 3'h2,
        RCW_STRETCH = 3'h4
    } rcw_state_e;

    // reset cause flags, laid out as register bits 6..0
    typedef struct packed {
        logic cnv;
        logic cmp;
        logic sw;
        logic wdog;
        logic mcd;
        logic por;
        logic pin;
    } rcw_flags_s;

    // asynchronous reset-source pins
    typedef struct packed {
        logic supply_low;
        logic supply_monitor_enable_pin;
        logic cmp;
        logic cnv;
        logic pin;
    } rcw_pins_s;

endpackage

// ===== hw/rcw_wdog_counter.sv
/*
 * 21-bit watchdog counter with a power-of-four interval selector.
 * Assumes run and restart come from logic on the same clock.
 */
`include "rcw_map.svh"

module rcw_wdog_counter #(
    parameter int CNT_W = `RCW_WD_CNT_W
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // control
    input wire logic run,
    input wire logic restart,
    input wire logic [2:0] sel,
    // timeout pulse
    output logic expire
);

    logic [CNT_W-1:0] cnt_ff;
    logic expire_ff;

    // last count value for an interval of four to the power of three plus sel
    function automatic logic [CNT_W-1:0] last_count(input logic [2:0] s);
        int e;
        e = 2 * (`RCW_WD_BASE_EXP + int'(s));
        return CNT_W'((1 << e) - 1);
    endfunction

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_ff <= '0;
            expire_ff <= 1'b0;
        end else begin
            expire_ff <= 1'b0;
            if (!run || restart) begin
                cnt_ff <= '0;
            end else if (cnt_ff == last_count(sel)) begin
                cnt_ff <= '0;
                expire_ff <= 1'b1;
            end else begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end

    assign expire = expire_ff;

    a_wd_interval_len: assert property (@(posedge clock) disable iff (sys_rst)
        expire_ff |-> ($past(cnt_ff) == last_count($past(sel))) && $past(run))
        else $error("watchdog expired at wrong count");

endmodule // rcw_wdog_counter

// ===== hw/rcw_mcd.sv
/*
 * Missing clock detector: times the gap between system clock ticks.
 * Assumes clk_tick pulses once per delivered system clock, on this clock.
 */
`include "rcw_map.svh"

module rcw_mcd #(
    parameter int CYCLES = `RCW_MCD_MIN_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // control and activity
    input wire logic enable,
    input wire logic clk_tick,
    // timeout pulse
    output logic timeout
);

    localparam int GW = $clog2(CYCLES + 1);

    logic [GW-1:0] gap_ff;
    logic timeout_ff;

    // gap timer, restarted by each tick
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            gap_ff <= '0;
            timeout_ff <= 1'b0;
        end else begin
            timeout_ff <= 1'b0;
            if (!enable || clk_tick) begin
                gap_ff <= '0;
            end else if (gap_ff == GW'(CYCLES - 1)) begin
                gap_ff <= '0;
                timeout_ff <= 1'b1;
            end else begin
                gap_ff <= gap_ff + 1'b1;
            end
        end
    end

    assign timeout = timeout_ff;

    a_mcd_gap_len: assert property (@(posedge clock) disable iff (sys_rst)
        timeout_ff |-> ($past(gap_ff) == GW'(CYCLES - 1)) && $past(enable) && !$past(clk_tick))
        else $error("missing clock timeout at wrong gap");

endmodule // rcw_mcd

// ===== tb/testbench.sv
/*
 * Self-checking bench for the reset-cause and watchdog block.
 * Assumes the design files under hw/ are compiled first; drives the register port and pins.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr_en = 1'b0;
    logic sfr_rd_en = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic clk_tick = 1'b1;
    logic pin_drv = 1'b1, cnv = 1'b1, cmp = 1'b1, supply_monitor_enable_pin = 1'b0, sup = 1'b0;
    logic core_rst, rst_pin_o, rst_pin_oe, oe;
    rcw_pkg::rcw_pins_s pins;
    int fail_count = 0;
    int check_count = 0;
    int cyc = 0;
    int n;

    // reset pin is open drain with a pull-up: low while either party pulls
    assign pins = {sup, supply_monitor_enable_pin, cmp, cnv, pin_drv & ~rst_pin_oe};

    rcw_reset_ctrl #(.MCD_CYCLES(20)) i_rcw_reset_ctrl (
        .clock(clock), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
        .sfr_rd_en(sfr_rd_en), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .async_pins(pins), .clk_tick(clk_tick), .core_rst(core_rst),
        .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe));

    // clock and hang guard
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    // step to just after the next rising edge
    task automatic tick();
        @(posedge clock);
        #1;
    endtask

    // compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one write, then an idle cycle so strobes never merge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr_en = 1'b1;
        tick();
        sfr_wr_en = 1'b0;
        tick();
    endtask

    // read and compare the returned byte
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr = a;
        sfr_rd_en = 1'b1;
        tick();
        sfr_rd_en = 1'b0;
        chk(sfr_rdata, exp);
        tick();
    endtask

    // back-to-back disable pair
    task automatic dis();
        sfr_addr = 8'hff;
        sfr_wdata = 8'hde;
        sfr_wr_en = 1'b1;
        tick();
        sfr_wdata = 8'had;
        tick();
        sfr_wr_en = 1'b0;
        tick();
    endtask

    // wait for a reset, count its high cycles, note any pin drive
    task automatic wait_rst(output int hi, output logic pd);
        hi = 0;
        pd = 1'b0;
        for (int i = 0; i < 300 && core_rst !== 1'b1; i++) tick();
        while (core_rst === 1'b1 && hi < 400) begin
            pd = pd | rst_pin_oe;
            hi++;
            tick();
        end
    endtask

    // watchdog command sequences
    task automatic s_wdcmd();
        wr(8'hff, 8'h03);
        rdc(8'hff, 8'h13);
        wr(8'hff, 8'h84);
        rdc(8'hff, 8'h13);
        wr(8'hff, 8'hde);
        repeat (4) tick();
        wr(8'hff, 8'had);
        rdc(8'hff, 8'h13);
        dis();
        rdc(8'hff, 8'h03);
        wr(8'hff, 8'hff);
        rdc(8'hff, 8'h03);
        wr(8'hff, 8'ha5);
        rdc(8'hff, 8'h13);
        dis();
        rdc(8'hff, 8'h13);
    endtask

    // watchdog expiry at the shortest interval
    task automatic s_wdog();
        wr(8'hff, 8'h00);
        wr(8'hff, 8'ha5);
        n = 0;
        while (core_rst !== 1'b1 && n < 100) begin
            n++;
            tick();
        end
        chk({7'h0, n > 55 && n < 70}, 8'h01);
        wait_rst(n, oe);
        chk({7'h0, oe}, 8'h00);
        rdc(8'hef, 8'h08);
        rdc(8'hff, 8'h17);
        dis();
        rdc(8'hff, 8'h07);
    endtask

    // optional source: ignored while off, resets once enabled
    task automatic s_src(input int b);
        if (b == 5) cmp = 1'b0;
        else if (b == 6) cnv = 1'b0;
        else clk_tick = 1'b0;
        repeat (30) tick();
        chk({7'h0, core_rst}, 8'h00);
        wr(8'hef, 8'(1 << b));
        wait_rst(n, oe);
        chk({7'h0, oe}, 8'h00);
        cmp = 1'b1;
        cnv = 1'b1;
        clk_tick = 1'b1;
        rdc(8'hef, 8'(1 << b));
    endtask

    // software, pin, forced and monitor resets
    task automatic s_resets();
        wr(8'hef, 8'h10);
        wait_rst(n, oe);
        chk({7'h0, n >= 12 && !oe}, 8'h01);
        rdc(8'hef, 8'h10);
        pin_drv = 1'b0;
        repeat (5) tick();
        pin_drv = 1'b1;
        n = 0;
        while (core_rst === 1'b1 && n < 100) begin
            n++;
            tick();
        end
        chk({7'h0, n >= 12}, 8'h01);
        rdc(8'hef, 8'h01);
        wr(8'hef, 8'h01);
        wait_rst(n, oe);
        chk({7'h0, oe}, 8'h01);
        chk({7'h0, rst_pin_o}, 8'h00);
        rdc(8'hef, 8'h02);
        supply_monitor_enable_pin = 1'b1;
        repeat (2) tick();
        wr(8'hef, 8'h00);
        sup = 1'b1;
        repeat (8) tick();
        chk({7'h0, core_rst}, 8'h00);
        sup = 1'b0;
        repeat (2) tick();
        wr(8'hef, 8'h02);
        sup = 1'b1;
        repeat (6) tick();
        chk({7'h0, core_rst}, 8'h01);
        sup = 1'b0;
        wait_rst(n, oe);
        rdc(8'hef, 8'h02);
        supply_monitor_enable_pin = 1'b0;
    endtask

    // counts and verdict
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (4) tick();
        sys_rst = 1'b0;
        wait_rst(n, oe);
        rdc(8'hef, 8'h02);
        rdc(8'hff, 8'h17);
        s_wdcmd();
        s_wdog();
        s_src(5);
        s_src(6);
        s_src(2);
        s_resets();
        wr(8'hff, 8'hff);
        sys_rst = 1'b1;
        tick();
        sys_rst = 1'b0;
        wait_rst(n, oe);
        rdc(8'hef, 8'h02);
        rdc(8'hff, 8'h17);
        dis();
        rdc(8'hff, 8'h07);
        wrap_up();
    end
endmodule // testbench
